// ---- design/chan_monitor.sv ----
// captures one selected channel's byte out of a 24-channel frame stream
module chan_monitor
#(
   parameter int SEL_W = 5
)
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [SEL_W-1:0] sel_in,
   input wire logic [SEL_W-1:0] chan_in,
   input wire logic [7:0] data_in,
   input wire logic valid_in,
   output logic [7:0] mon_out
);
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         mon_out <= 8'h00;
      else if (valid_in && (chan_in == sel_in))
         mon_out <= data_in;
   end
endmodule : chan_monitor

// ---- design/loop_ctl_consts.svh ----
// register offsets, field positions and reset values for the loopback and monitor control bank
`ifndef LOOP_CTL_CONSTS_SVH
`define LOOP_CTL_CONSTS_SVH
`define LINE_RESET_REMOTE_LOOP_CONTROL_IDX 5'h0a
`define TX_CRC_LOOP_MONITOR_CONTROL_IDX 5'h19
`define RX_CRC_MONITOR_CONTROL_IDX 5'h1e
`define ELASTIC_STORE_CONTROL_IDX 5'h1f
`define TX_CHANNEL_MONITOR_IDX 5'h1c
`define RX_CHANNEL_MONITOR_IDX 5'h1d
`define LOOP_STATUS_IDX 5'h1b
`define ADDR_W 7
`define CTRL_RESET 8'h00
`define TX_CRC_BIT 7
`define LOCAL_LOOP_BIT 6
`define LINE_ALARM_BIT 5
`define RX_CRC_BIT 7
`define LINE_RESET_BIT 7
`define REMOTE_LOOP_BIT 6
`define ES_RESET_BIT 6
`define TX_CTRL_MASK 8'hff
`define RX_CTRL_MASK 8'h9f
`define LINE_CTRL_MASK 8'hc0
`define ES_CTRL_MASK 8'h40
`define RESET_PULSE_CYCLES 4'h4
`endif

// ---- design/loop_ctl_pkg.sv ----
// types shared by the loopback and monitor control bank
package loop_ctl_pkg;
   typedef struct packed {
      logic pos;
      logic neg;
   } line_pair_type;
   typedef struct packed {
      logic read;
      logic write;
      logic [6:0] address;
      logic [31:0] writedata;
   } avmm_req_type;
endpackage : loop_ctl_pkg

// ---- design/rise_pulse.sv ----
// stretched pulse started by a zero-to-one change of a control bit
`include "loop_ctl_consts.svh"
module rise_pulse
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic level_in,
   output logic pulse_out
);
   logic prev_q;
   logic [3:0] cnt_q;

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         prev_q <= 1'b0;
      else
         prev_q <= level_in;
   end

   // only a fresh rise restarts; holding the bit high does nothing more
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         cnt_q <= 4'h0;
      else if (level_in && !prev_q)
         cnt_q <= `RESET_PULSE_CYCLES;
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         pulse_out <= 1'b0;
      else
         pulse_out <= (level_in && !prev_q) || (cnt_q > 4'h1);
   end
endmodule : rise_pulse

// ---- design/t1_loopback_monitor_control.sv ----
// loopback, channel monitor, crc variant and line reset control bank with avalon slave
//
// Summary of operation
// [RULE1] local loop bit one enters local loopback, zero leaves it
// [RULE2] in local loopback transmit output continues unless line alarm forcing overrides
// [RULE3] local loopback replaces receive line data with the transmitted data
// [RULE4] locally looped data passes through the jitter attenuator path
// [RULE5] system must not tie recovered clock to transmit clock in local loopback
// [RULE6] software should put jitter attenuator on transmit side in local loopback
// [RULE7] five-bit transmit monitor field picks channel copied to transmit monitor register
// [RULE8] remote loop bit one enters remote loopback, zero leaves it
// [RULE9] remote loopback sends received line pair straight back out on transmit pair
// [RULE10] receive framer keeps processing incoming data during remote loopback
// [RULE11] remote loopback ignores transmit formatter output on transmit line outputs
// [RULE12] host must write all registers after power-up, test registers to zero
// [RULE13] host toggles elastic store reset zero to one once system clocks settle
// [RULE14] host writes zero to every unassigned control bit
// [RULE15] elastic store reset rise forces stores to known depth; re-arm needs clear
// [RULE16] transmit and receive bits select standard or japanese crc6 per direction
// [RULE17] five-bit receive monitor field picks channel copied to receive monitor register
// [RULE18] line reset rise resets clock recovery and jitter attenuator; re-arm needs clear
`include "loop_ctl_consts.svh"
module t1_loopback_monitor_control
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   // avalon-mm slave
   input wire logic [6:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // line side
   input wire loop_ctl_pkg::line_pair_type rx_line_in,
   input wire loop_ctl_pkg::line_pair_type tx_formatter_in,
   input wire loop_ctl_pkg::line_pair_type jitter_att_in,
   output loop_ctl_pkg::line_pair_type tx_line_out,
   output loop_ctl_pkg::line_pair_type framer_rx_out,
   output loop_ctl_pkg::line_pair_type jitter_att_out,
   // channel streams for monitors
   input wire logic [4:0] tx_chan_in,
   input wire logic [7:0] tx_chan_data_in,
   input wire logic tx_chan_valid_in,
   input wire logic [4:0] rx_chan_in,
   input wire logic [7:0] rx_chan_data_in,
   input wire logic rx_chan_valid_in,
   // controls to the datapath
   output logic tx_crc_variant_select_out,
   output logic rx_crc_variant_select_out,
   output logic local_loop_enable_out,
   output logic remote_loop_enable_out,
   output logic line_iface_reset_out,
   output logic elastic_store_reset_out
);
   import loop_ctl_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] tx_ctrl_q;
   logic [7:0] rx_ctrl_q;
   logic [7:0] line_ctrl_q;
   logic [7:0] es_ctrl_q;
   logic [7:0] tx_channel_monitor_reg;
   logic [7:0] rx_channel_monitor_reg;
   logic line_reset_pulse;
   logic es_reset_pulse;
   logic in_answer;
   logic [4:0] word_idx;
   logic addr_ok;
   logic wr_take;
   logic rd_take;
   logic [31:0] read_word_d;

   // ****************************************
   // bus handshake
   // ****************************************
   // two states give the one fixed wait state; a request is never answered in its first cycle
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_type;
   bus_state_type bus_state_q;
   bus_state_type bus_state_d;

   // byte address must be word aligned; index = byte address / 4
   assign word_idx = avs_address_in[6:2];
   assign addr_ok = (avs_address_in[1:0] == 2'b00);
   assign in_answer = (bus_state_q == BUS_ANSWER);
   // reads are decoded when first seen so data stands with the answer; writes land with it
   assign wr_take = avs_write_in && in_answer;
   assign rd_take = avs_read_in && !in_answer;

   always_comb
   begin
      bus_state_d = bus_state_q;
      case (bus_state_q)
         BUS_IDLE:
         begin
            if (avs_read_in || avs_write_in)
               bus_state_d = BUS_ANSWER;
         end
         BUS_ANSWER:
         begin
            bus_state_d = BUS_IDLE;
         end
         default:
         begin
            bus_state_d = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         bus_state_q <= BUS_IDLE;
      else
         bus_state_q <= bus_state_d;
   end

   // waitrequest falls exactly when the answer state is entered
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         avs_waitrequest_out <= 1'b1;
      else
         avs_waitrequest_out <= (bus_state_d != BUS_ANSWER);
   end

   // ****************************************
   // control registers
   // ****************************************
   // unassigned bits are stored as zero whatever the host writes
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         tx_ctrl_q <= `CTRL_RESET;
      else if (wr_take && addr_ok && (word_idx == `TX_CRC_LOOP_MONITOR_CONTROL_IDX))
         tx_ctrl_q <= avs_writedata_in[7:0] & `TX_CTRL_MASK; // see [RULE1]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rx_ctrl_q <= `CTRL_RESET;
      else if (wr_take && addr_ok && (word_idx == `RX_CRC_MONITOR_CONTROL_IDX))
         rx_ctrl_q <= avs_writedata_in[7:0] & `RX_CTRL_MASK; // see [RULE16]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         line_ctrl_q <= `CTRL_RESET;
      else if (wr_take && addr_ok && (word_idx == `LINE_RESET_REMOTE_LOOP_CONTROL_IDX))
         line_ctrl_q <= avs_writedata_in[7:0] & `LINE_CTRL_MASK; // see [RULE8]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         es_ctrl_q <= `CTRL_RESET;
      else if (wr_take && addr_ok && (word_idx == `ELASTIC_STORE_CONTROL_IDX))
         es_ctrl_q <= avs_writedata_in[7:0] & `ES_CTRL_MASK; // see [RULE15]
   end

   // ****************************************
   // read path
   // ****************************************
   always_comb
   begin
      read_word_d = 32'h0000_0000;
      if (!addr_ok)
         read_word_d = 32'h0000_0000;
      else if (word_idx == `TX_CRC_LOOP_MONITOR_CONTROL_IDX)
         read_word_d = {24'h000000, tx_ctrl_q};
      else if (word_idx == `RX_CRC_MONITOR_CONTROL_IDX)
         read_word_d = {24'h000000, rx_ctrl_q};
      else if (word_idx == `LINE_RESET_REMOTE_LOOP_CONTROL_IDX)
         read_word_d = {24'h000000, line_ctrl_q};
      else if (word_idx == `ELASTIC_STORE_CONTROL_IDX)
         read_word_d = {24'h000000, es_ctrl_q};
      else if (word_idx == `TX_CHANNEL_MONITOR_IDX)
         read_word_d = {24'h000000, tx_channel_monitor_reg};
      else if (word_idx == `RX_CHANNEL_MONITOR_IDX)
         read_word_d = {24'h000000, rx_channel_monitor_reg};
      else if (word_idx == `LOOP_STATUS_IDX)
         read_word_d = {28'h0000000, es_reset_pulse, line_reset_pulse,
                        line_ctrl_q[`REMOTE_LOOP_BIT], tx_ctrl_q[`LOCAL_LOOP_BIT]};
      else
         read_word_d = 32'h0000_0000;
   end

   // read data is registered in the same cycle waitrequest falls
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         avs_readdata_out <= 32'h0000_0000;
      else if (rd_take)
         avs_readdata_out <= read_word_d;
   end

   // ****************************************
   // channel monitors
   // ****************************************
   chan_monitor #(.SEL_W(5)) tx_mon
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .sel_in(tx_ctrl_q[4:0]), // see [RULE7]
      .chan_in(tx_chan_in),
      .data_in(tx_chan_data_in),
      .valid_in(tx_chan_valid_in),
      .mon_out(tx_channel_monitor_reg)
   );

   chan_monitor #(.SEL_W(5)) rx_mon
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .sel_in(rx_ctrl_q[4:0]), // see [RULE17]
      .chan_in(rx_chan_in),
      .data_in(rx_chan_data_in),
      .valid_in(rx_chan_valid_in),
      .mon_out(rx_channel_monitor_reg)
   );

   // ****************************************
   // edge-triggered internal resets
   // ****************************************
   rise_pulse line_rst
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .level_in(line_ctrl_q[`LINE_RESET_BIT]), // see [RULE18]
      .pulse_out(line_reset_pulse)
   );

   rise_pulse es_rst
   (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .level_in(es_ctrl_q[`ES_RESET_BIT]), // see [RULE15]
      .pulse_out(es_reset_pulse)
   );

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         line_iface_reset_out <= 1'b0;
      else
         line_iface_reset_out <= line_reset_pulse; // see [RULE18]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         elastic_store_reset_out <= 1'b0;
      else
         elastic_store_reset_out <= es_reset_pulse; // see [RULE15]
   end

   // ****************************************
   // mode outputs
   // ****************************************
   // decoded control bits; the two loop bits feed the mode outputs, all three feed the steering below
   logic local_loop_sel;
   logic remote_loop_sel;
   logic alarm_force_sel;
   assign local_loop_sel = tx_ctrl_q[`LOCAL_LOOP_BIT];
   assign remote_loop_sel = line_ctrl_q[`REMOTE_LOOP_BIT];
   assign alarm_force_sel = tx_ctrl_q[`LINE_ALARM_BIT];

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         tx_crc_variant_select_out <= 1'b0;
      else
         tx_crc_variant_select_out <= tx_ctrl_q[`TX_CRC_BIT]; // see [RULE16]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         rx_crc_variant_select_out <= 1'b0;
      else
         rx_crc_variant_select_out <= rx_ctrl_q[`RX_CRC_BIT]; // see [RULE16]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         local_loop_enable_out <= 1'b0;
      else
         local_loop_enable_out <= local_loop_sel; // see [RULE1]
   end

   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         remote_loop_enable_out <= 1'b0;
      else
         remote_loop_enable_out <= remote_loop_sel; // see [RULE8]
   end

   // ****************************************
   // line data steering
   // ****************************************
   // remote loop wins over alarm forcing and over local loop on the transmit pair
   // limitation: nothing here stops the recovered clock feeding the transmit clock
   // in local loop; the board must keep those two apart
   // transmit pair: remote loop echoes the receive pair, alarm force holds pos at one and neg at zero
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         tx_line_out <= '0;
      else if (remote_loop_sel)
         tx_line_out <= rx_line_in; // see [RULE9] see [RULE11]
      else if (alarm_force_sel)
         tx_line_out <= '{pos: 1'b1, neg: 1'b0};
      else
         tx_line_out <= tx_formatter_in; // see [RULE2]
   end

   // attenuator input: the transmitted pair in local loop, otherwise the line
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         jitter_att_out <= '0;
      else if (local_loop_sel)
         jitter_att_out <= tx_formatter_in; // see [RULE3] see [RULE4]
      else
         jitter_att_out <= rx_line_in;
   end

   // framer sees the attenuator output in local loop, the line input otherwise
   always_ff @(posedge core_clk_in or posedge rst_in)
   begin
      if (rst_in)
         framer_rx_out <= '0;
      else if (local_loop_sel)
         framer_rx_out <= jitter_att_in; // see [RULE4]
      else
         framer_rx_out <= rx_line_in; // see [RULE10]
   end
endmodule : t1_loopback_monitor_control

// ---- test/host_model.sv ----
// host processor model on the avalon control port
module host_model
(
   input wire logic core_clk_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   output logic [6:0] avs_address_in,
   output logic avs_read_in,
   output logic avs_write_in,
   output logic [31:0] avs_writedata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic hung = 1'b0;
   initial
   begin
      avs_address_in = 7'h00;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h0;
   end
   task automatic access(input logic rd, input logic [6:0] a, input logic [7:0] d,
      output logic [31:0] q);
      int n = 0;
      @(posedge core_clk_in);
      avs_address_in <= a;
      avs_read_in <= rd;
      avs_write_in <= !rd;
      avs_writedata_in <= {24'h0, d};
      do
      begin
         @(posedge core_clk_in);
         n++;
      end
      while (avs_waitrequest_out && n < 50);
      if (avs_waitrequest_out)
         hung = 1'b1;
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      // released data must not look valid
      avs_writedata_in <= ~avs_writedata_in;
   endtask : access
   // no clock feedback and no receive-side attenuator placement
   task automatic power_up();
      logic [31:0] q;
      access(1'b0, 7'h64, 8'h00, q);
      access(1'b0, 7'h78, 8'h00, q);
      access(1'b0, 7'h28, 8'h00, q);
      access(1'b0, 7'h7c, 8'h00, q);
      access(1'b0, 7'h7c, 8'h40, q);
   endtask : power_up
endmodule : host_model

// ---- test/loop_ctl_checker.sv ----
// port assertions for the loopback and monitor control bank
module loop_ctl_checker
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire loop_ctl_pkg::line_pair_type rx_line_in,
   input wire loop_ctl_pkg::line_pair_type tx_formatter_in,
   input wire loop_ctl_pkg::line_pair_type jitter_att_in,
   input wire loop_ctl_pkg::line_pair_type tx_line_out,
   input wire loop_ctl_pkg::line_pair_type framer_rx_out,
   input wire loop_ctl_pkg::line_pair_type jitter_att_out,
   input wire logic local_loop_enable_out,
   input wire logic remote_loop_enable_out,
   input wire logic line_iface_reset_out,
   input wire logic elastic_store_reset_out
);
   import loop_ctl_pkg::*;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // ****************
   // assertions
   // ****************
   AST_WAIT_ONE:
      assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("wait low twice");
   AST_WAIT_ANSWER:
      assert property ($rose(avs_read_in || avs_write_in) |-> ##[1:2] !avs_waitrequest_out)
      else $error("no answer");
   AST_READ_UPPER:
      assert property (avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
      else $error("read upper bits set");
   AST_REMOTE_ECHO:
      assert property (remote_loop_enable_out && $past(remote_loop_enable_out)
         |-> tx_line_out == $past(rx_line_in)) else $error("remote echo wrong");
   AST_LOCAL_ATT:
      assert property (local_loop_enable_out && $past(local_loop_enable_out)
         |-> jitter_att_out == $past(tx_formatter_in)) else $error("att input wrong");
   AST_LOCAL_RX:
      assert property (local_loop_enable_out && $past(local_loop_enable_out)
         && !remote_loop_enable_out && !$past(remote_loop_enable_out)
         |-> framer_rx_out == $past(jitter_att_in)) else $error("local rx wrong");
   AST_LOCAL_TX:
      assert property (local_loop_enable_out && !remote_loop_enable_out
         && !$past(remote_loop_enable_out) |-> tx_line_out == $past(tx_formatter_in)
         || tx_line_out == 2'b10) else $error("local tx wrong");
   AST_LINE_PULSE:
      assert property ($rose(line_iface_reset_out) |-> line_iface_reset_out[*4]
         ##1 !line_iface_reset_out) else $error("line reset pulse wrong");
   AST_ES_PULSE:
      assert property ($rose(elastic_store_reset_out) |-> elastic_store_reset_out[*4]
         ##1 !elastic_store_reset_out) else $error("store reset pulse wrong");
   cover property (remote_loop_enable_out ##1 remote_loop_enable_out);
   cover property (local_loop_enable_out ##1 local_loop_enable_out);
   cover property ($rose(line_iface_reset_out));
endmodule : loop_ctl_checker

bind t1_loopback_monitor_control loop_ctl_checker loop_ctl_checker_i (.core_clk_in, .rst_in,
   .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .rx_line_in,
   .tx_formatter_in, .jitter_att_in, .tx_line_out, .framer_rx_out, .jitter_att_out,
   .local_loop_enable_out,
   .remote_loop_enable_out, .line_iface_reset_out, .elastic_store_reset_out);

// ---- test/tb_top.sv ----
// self-checking bench for the loopback and monitor control bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import loop_ctl_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [6:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [31:0] avs_writedata_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   line_pair_type rx_line_in = 2'b01;
   line_pair_type tx_formatter_in = 2'b11;
   line_pair_type jitter_att_in = 2'b10;
   line_pair_type tx_line_out;
   line_pair_type framer_rx_out;
   logic [4:0] tx_chan_in = 5'h00;
   logic [7:0] tx_chan_data_in = 8'h00;
   logic tx_chan_valid_in = 1'b0;
   logic [4:0] rx_chan_in = 5'h00;
   logic [7:0] rx_chan_data_in = 8'h00;
   logic rx_chan_valid_in = 1'b0;
   logic tx_crc, rx_crc, local_on, remote_on, line_rst, es_rst;
   line_pair_type att_out;
   int num_errors = 0;
   int num_checks = 0;
   int n;
   t1_loopback_monitor_control t1_loopback_monitor_control_i (.core_clk_in, .rst_in,
      .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
      .avs_waitrequest_out, .rx_line_in, .tx_formatter_in, .jitter_att_in, .tx_line_out,
      .framer_rx_out, .jitter_att_out(att_out), .tx_chan_in, .tx_chan_data_in,
      .tx_chan_valid_in,
      .rx_chan_in, .rx_chan_data_in, .rx_chan_valid_in, .tx_crc_variant_select_out(tx_crc),
      .rx_crc_variant_select_out(rx_crc), .local_loop_enable_out(local_on),
      .remote_loop_enable_out(remote_on), .line_iface_reset_out(line_rst),
      .elastic_store_reset_out(es_rst));
   host_model host_model_i (.core_clk_in, .avs_readdata_out, .avs_waitrequest_out,
      .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in);
   initial
   begin
      forever #4 core_clk_in = ~core_clk_in;
   end
   // ****************
   // helpers
   // ****************
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic acc(input logic rd, input logic [6:0] a, input logic [7:0] d,
      output logic [31:0] q);
      host_model_i.access(rd, a, d, q);
      if (host_model_i.hung)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask : acc
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [31:0] q;
      acc(1'b0, a, d, q);
   endtask : wr
   task automatic rdchk(input logic [6:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      acc(1'b1, a, 8'h00, q);
      chk(what, exp, q);
   endtask : rdchk
   task automatic idle(input int c);
      repeat (c) @(posedge core_clk_in);
      #1;
   endtask : idle
   // high cycles of the line reset (sel 0) or store reset (sel 1) after a write
   task automatic pulse_len(input logic sel);
      n = 0;
      repeat (12)
      begin
         idle(1);
         if ((sel ? es_rst : line_rst) === 1'b1)
            n++;
      end
   endtask : pulse_len
   // ****************
   // scenarios
   // ****************
   task automatic check_regs();
      wr(7'h64, 8'h80);
      wr(7'h78, 8'hff);
      rdchk(7'h78, 32'h9f, "ctl6 mask");
      idle(3);
      chk("tx crc", 32'h1, 32'(tx_crc));
      chk("rx crc", 32'h1, 32'(rx_crc));
      wr(7'h29, 8'h40);
      rdchk(7'h28, 32'h0, "unaligned");
      rdchk(7'h04, 32'h0, "unmapped");
   endtask : check_regs
   task automatic check_local();
      wr(7'h64, 8'h40);
      idle(4);
      chk("local on", 32'h1, 32'(local_on));
      chk("tx kept", 32'h3, 32'(tx_line_out));
      chk("rx replaced", 32'h2, 32'(framer_rx_out));
      chk("att in", 32'h3, 32'(att_out));
      rdchk(7'h6c, 32'h1, "status");
      wr(7'h64, 8'h60);
      idle(4);
      chk("alarm", 32'h2, 32'(tx_line_out));
      wr(7'h64, 8'h00);
      idle(4);
      chk("local off", 32'h0, 32'(local_on));
   endtask : check_local
   task automatic check_remote();
      wr(7'h28, 8'h7f);
      rdchk(7'h28, 32'h40, "ctl7 mask");
      idle(4);
      chk("remote on", 32'h1, 32'(remote_on));
      chk("echo", 32'h1, 32'(tx_line_out));
      chk("framer", 32'h1, 32'(framer_rx_out));
      chk("att line", 32'h1, 32'(att_out));
      wr(7'h28, 8'h00);
      idle(4);
      chk("remote off", 32'h0, 32'(remote_on));
      chk("tx normal", 32'h3, 32'(tx_line_out));
   endtask : check_remote
   task automatic check_monitor();
      wr(7'h64, 8'h17);
      wr(7'h78, 8'h11);
      for (int c = 0; c < 24; c++)
      begin
         @(posedge core_clk_in);
         tx_chan_in <= c[4:0];
         tx_chan_data_in <= 8'ha5 ^ c[7:0];
         tx_chan_valid_in <= 1'b1;
         rx_chan_in <= c[4:0];
         rx_chan_data_in <= 8'h30 + c[7:0];
         rx_chan_valid_in <= 1'b1;
      end
      @(posedge core_clk_in);
      tx_chan_valid_in <= 1'b0;
      rx_chan_valid_in <= 1'b0;
      rdchk(7'h70, 32'hb2, "tx monitor");
      rdchk(7'h74, 32'h41, "rx monitor");
   endtask : check_monitor
   task automatic check_resets();
      wr(7'h28, 8'h80);
      pulse_len(1'b0);
      chk("line pulse", 32'h4, 32'(n));
      wr(7'h28, 8'h80);
      pulse_len(1'b0);
      chk("no rearm", 32'h0, 32'(n));
      wr(7'h7c, 8'h00);
      wr(7'h7c, 8'h40);
      pulse_len(1'b1);
      chk("store pulse", 32'h4, 32'(n));
   endtask : check_resets
   initial
   begin
      repeat (5) @(posedge core_clk_in);
      rst_in <= 1'b0;
      host_model_i.power_up();
      chk("host hang", 32'h0, 32'(host_model_i.hung));
      check_regs();
      check_local();
      check_remote();
      check_monitor();
      check_resets();
      tally_and_finish();
   end
endmodule : tb_top
